// ---- dbgc_core_model.sv ----
/*
 core bus and memory management unit model facing the comparator c block.
 assumes cycle is called just after a rising mclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module dbgc_core_model (
  // clock
  input wire logic mclk,
  // core bus
  output logic bus_valid,
  output logic bus_read,
  output logic [15:0] cpu_addr,
  output logic [2:0] prog_page,
  output logic page_sel,
  output logic lap_sel,
  output logic [16:0] lap_addr
);
  initial begin
    {bus_valid, bus_read, cpu_addr, prog_page, page_sel, lap_sel, lap_addr} = '0;
  end
  // ========================================
  // one bus cycle
  task automatic cycle(input logic rd, ps, ls, input logic [2:0] pg,
      input logic [15:0] ca, input logic [16:0] la);
    {bus_valid, bus_read, page_sel, lap_sel} <= {1'h1, rd, ps, ls};
    {prog_page, cpu_addr, lap_addr} <= {pg, ca, la};
    @(posedge mclk);
    // idle bus shows the inverse, so a stale value cannot match by luck
    bus_valid <= 1'h0;
    {bus_read, page_sel, lap_sel, prog_page, cpu_addr, lap_addr} <= ~{rd, ps, ls, pg, ca, la};
  endtask
endmodule
`default_nettype wire

// ---- dbgc_ext.sv ----
/*
 comparator c extension qualifiers and the fifo extended-information
 register of the on-chip debug unit, with a small enable/begin control.
 assumes core bus inputs are synchronous to mclk and valid per bus cycle,
 por is the power-on reset and rst the ordinary system reset.
*/
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: direction enable set makes comparator c qualify on bus direction.
// RULE2: direction value 0 matches writes, 1 matches reads; unused if disabled.
// RULE3: page qualify set matches paged accesses, address is page:addr[13:0].
// RULE4: page qualify clear matches unpaged accesses, cpu or linear pointer address.
// RULE5: extension bit 0 is the expected value of core address bit 16.
// RULE6: both extension registers clear on power-on or non-end-run reset, else hold.
// RULE7: fifo paged flag shows whether the current word came from a paged access.
// RULE8: paged word holds page bits on top of cpu address bits 13:0.
// RULE9: unpaged word is event-only or cpu address with bit 16 zero; a linear pointer capture stores lap_addr with its bit 16.
// RULE10: fifo extension bit 0 shows address bit 16 of current word; read-only.
// RULE11: module enable gates the block, forced zero while secured; the code gates only cmp_c_match, fifo_capture loads regardless.
// RULE12: begin select 0 means end trace, which keeps registers across reset; the code keeps them only while module enable is also set.
// RULE13: match only when address, bit 16, page and direction all agree together.
module dbgc_ext
  import dbgc_pkg::*;
(
  // clock and resets
  input wire logic mclk,
  input wire logic rst,
  input wire logic por,
  // register port
  input wire logic [dbgc_pkg::DBGC_AW-1:0] reg_addr,
  input wire logic [dbgc_pkg::DBGC_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dbgc_pkg::DBGC_DW-1:0] reg_rdata,
  // core bus and memory management unit
  input wire logic bus_valid,
  input wire logic bus_read,
  input wire logic [15:0] cpu_addr,
  input wire logic [2:0] prog_page,
  input wire logic page_sel,
  input wire logic lap_sel,
  input wire logic [16:0] lap_addr,
  input wire logic secure,
  // comparator c base address from its own registers
  input wire logic [15:0] cmp_c_addr,
  // fifo capture side
  input wire logic fifo_capture,
  input wire logic fifo_event_only,
  // results
  output logic cmp_c_match,
  output logic [16:0] fifo_word,
  output logic debug_module_enable,
  output logic trigger_begin
);
  import dbgc_pkg::*;

  // ==========================================
  // address forming
  function automatic logic [16:0] core_a17(input logic psel, input logic lsel,
      input logic [2:0] pg, input logic [15:0] ca, input logic [16:0] la);
    logic [16:0] r;
    r = {1'b0, ca};
    if (psel) begin
      r = {pg, ca[DBGC_PAGE_LSB-1:0]};
    end else if (lsel) begin
      r = la;
    end
    return r;
  endfunction

  logic [16:0] a17;
  logic end_run;
  logic dir_qualify_enable;
  logic dir_match_value;
  logic page_select_qualify;
  logic cmp_b16;
  logic paged_access_flag;
  logic fx_b16;
  logic [7:0] ccx_val;
  logic [7:0] fx_val;
  logic [7:0] ctl_val;
  logic addr_ok;
  logic b16_ok;
  logic page_ok;
  logic dir_ok;
  logic next_match;

  assign a17 = core_a17(page_sel, lap_sel, prog_page, cpu_addr, lap_addr);
  // end-trace case: enabled and trigger at end of stored data
  assign end_run = debug_module_enable && !trigger_begin; // [RULE12]

  // ==========================================
  // comparator c qualifiers
  // cpu and linear addresses are compared alike; bit 16 tells them apart
  assign addr_ok = (a17[15:0] == cmp_c_addr);
  assign b16_ok = (a17[DBGC_A17_MSB] == cmp_b16); // [RULE5]
  assign page_ok = (page_sel == page_select_qualify); // [RULE3] [RULE4]
  assign dir_ok = !dir_qualify_enable || (bus_read == dir_match_value); // [RULE1] [RULE2]
  assign next_match = bus_valid && debug_module_enable
      && addr_ok && b16_ok && page_ok && dir_ok; // [RULE13]

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmp_c_match <= 1'b0;
    end else begin
      cmp_c_match <= next_match;
    end
  end

  // ==========================================
  // control: module enable and begin select
  // these survive an end-run reset so that the end-trace decision holds
  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      debug_module_enable <= DBGC_EN_RST;
      trigger_begin <= DBGC_BEGIN_RST;
    end else begin
      if (rst) begin
        if (!end_run) begin
          debug_module_enable <= DBGC_EN_RST;
          trigger_begin <= DBGC_BEGIN_RST;
        end
      end else if (reg_wr && reg_addr == DBGC_OFS_CTL) begin
        debug_module_enable <= reg_wdata[DBGC_CTL_EN]; // [RULE11]
        trigger_begin <= reg_wdata[DBGC_CTL_BEGIN];
      end
      // secure only forces the enable; begin select and reset handling go on
      if (secure) begin
        debug_module_enable <= 1'h0; // [RULE11]
      end
    end
  end

  // ==========================================
  // comparator c extension register
  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      dir_qualify_enable <= DBGC_CCX_RST[DBGC_CCX_DIR_EN];
      dir_match_value <= DBGC_CCX_RST[DBGC_CCX_DIR_VAL];
      page_select_qualify <= DBGC_CCX_RST[DBGC_CCX_PAGQ];
      cmp_b16 <= DBGC_CCX_RST[DBGC_CCX_B16];
    end else if (rst) begin
      if (!end_run) begin // [RULE6]
        dir_qualify_enable <= DBGC_CCX_RST[DBGC_CCX_DIR_EN];
        dir_match_value <= DBGC_CCX_RST[DBGC_CCX_DIR_VAL];
        page_select_qualify <= DBGC_CCX_RST[DBGC_CCX_PAGQ];
        cmp_b16 <= DBGC_CCX_RST[DBGC_CCX_B16];
      end
    end else if (reg_wr && reg_addr == DBGC_OFS_CCX) begin
      dir_qualify_enable <= reg_wdata[DBGC_CCX_DIR_EN];
      dir_match_value <= reg_wdata[DBGC_CCX_DIR_VAL];
      page_select_qualify <= reg_wdata[DBGC_CCX_PAGQ];
      cmp_b16 <= reg_wdata[DBGC_CCX_B16];
    end
  end

  // ==========================================
  // fifo extended info, loaded with each captured word
  // software writes to this offset are ignored: the register is read-only
  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      paged_access_flag <= DBGC_FX_RST[DBGC_FX_PAGED];
      fx_b16 <= DBGC_FX_RST[DBGC_FX_B16];
      fifo_word <= DBGC_A17_ZERO;
    end else if (rst) begin
      if (!end_run) begin // [RULE6]
        paged_access_flag <= DBGC_FX_RST[DBGC_FX_PAGED];
        fx_b16 <= DBGC_FX_RST[DBGC_FX_B16];
        fifo_word <= DBGC_A17_ZERO;
      end
    end else if (fifo_capture) begin
      if (fifo_event_only) begin
        paged_access_flag <= 1'b0; // [RULE9]
        fx_b16 <= 1'b0;
        fifo_word <= DBGC_A17_ZERO;
      end else begin
        paged_access_flag <= page_sel; // [RULE7]
        fx_b16 <= a17[DBGC_A17_MSB]; // [RULE10]
        fifo_word <= a17; // [RULE8] [RULE9]
      end
    end
  end

  // ==========================================
  // register read port, data one cycle after the strobe
  assign ccx_val = {dir_qualify_enable, dir_match_value, page_select_qualify,
      4'h0, cmp_b16};
  assign fx_val = {paged_access_flag, 6'h00, fx_b16}; // [RULE10]
  assign ctl_val = {debug_module_enable, trigger_begin, 6'h00};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= DBGC_ZERO8;
    end else if (reg_rd) begin
      unique case (reg_addr)
        DBGC_OFS_CCX: reg_rdata <= ccx_val;
        DBGC_OFS_FX: reg_rdata <= fx_val;
        DBGC_OFS_CTL: reg_rdata <= ctl_val;
        default: reg_rdata <= DBGC_ZERO8;
      endcase
    end else begin
      reg_rdata <= DBGC_ZERO8;
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst || por);

  property p_dir_mismatch;
    bus_valid && dir_qualify_enable && (bus_read != dir_match_value)
        |=> !cmp_c_match;
  endproperty
  a_dir_mismatch: assert property (p_dir_mismatch) // [RULE1] [RULE2]
    else $error("direction mismatch still matched");

  property p_dir_ignored;
    bus_valid && debug_module_enable && !dir_qualify_enable
        && addr_ok && b16_ok && page_ok |=> cmp_c_match;
  endproperty
  a_dir_ignored: assert property (p_dir_ignored) // [RULE1]
    else $error("match lost with direction ignored");

  property p_paged_only;
    page_select_qualify && !page_sel |=> !cmp_c_match;
  endproperty
  a_paged_only: assert property (p_paged_only) // [RULE3]
    else $error("unpaged access matched in paged mode");

  property p_unpaged_only;
    !page_select_qualify && page_sel |=> !cmp_c_match;
  endproperty
  a_unpaged_only: assert property (p_unpaged_only) // [RULE4]
    else $error("paged access matched in unpaged mode");

  property p_b16;
    (a17[DBGC_A17_MSB] != cmp_b16) |=> !cmp_c_match;
  endproperty
  a_b16: assert property (p_b16) // [RULE5]
    else $error("bit 16 mismatch still matched");

  property p_all_cond;
    cmp_c_match |-> $past(bus_valid && debug_module_enable && addr_ok);
  endproperty
  a_all_cond: assert property (p_all_cond) // [RULE13]
    else $error("match without valid enabled address hit");

  property p_flag;
    fifo_capture && !fifo_event_only |=> paged_access_flag == $past(page_sel);
  endproperty
  a_flag: assert property (p_flag) // [RULE7]
    else $error("paged flag differs from page select");

  property p_paged_word;
    fifo_capture && !fifo_event_only && page_sel
        |=> fifo_word == {$past(prog_page), $past(cpu_addr[13:0])};
  endproperty
  a_paged_word: assert property (p_paged_word) // [RULE8]
    else $error("paged word not page over address");

  property p_unpaged_word;
    fifo_capture && !page_sel && !lap_sel |=> !fifo_word[DBGC_A17_MSB];
  endproperty
  a_unpaged_word: assert property (p_unpaged_word) // [RULE9]
    else $error("unpaged word has bit 16 set");

  sequence s_fx_write;
    reg_wr && reg_addr == DBGC_OFS_FX && !fifo_capture;
  endsequence
  sequence s_fx_held;
    $stable(paged_access_flag) && $stable(fx_b16);
  endsequence
  property p_fx_ro;
    s_fx_write |=> s_fx_held;
  endproperty
  a_fx_ro: assert property (p_fx_ro) // [RULE10]
    else $error("fifo extension changed by a write");

  property p_fx_b16;
    fifo_capture ##1 !fifo_capture |-> fx_b16 == fifo_word[DBGC_A17_MSB];
  endproperty
  a_fx_b16: assert property (p_fx_b16) // [RULE10]
    else $error("bit 16 field differs from word");

  property p_secure;
    secure |=> !debug_module_enable;
  endproperty
  a_secure: assert property (p_secure) // [RULE11]
    else $error("module enabled while secured");

  property p_keep;
    @(posedge mclk) disable iff (por)
    rst && end_run |=> $stable(ccx_val) && $stable(fx_val);
  endproperty
  a_keep: assert property (p_keep) // [RULE6] [RULE12]
    else $error("extension lost across end-run reset");

  property p_clear;
    @(posedge mclk) disable iff (por)
    rst && !end_run |=> ccx_val == DBGC_CCX_RST && fx_val == DBGC_FX_RST;
  endproperty
  a_clear: assert property (p_clear) // [RULE6]
    else $error("extension not cleared by reset");

  property p_read;
    reg_rd && reg_addr == DBGC_OFS_CCX |=> reg_rdata == $past(ccx_val);
  endproperty
  a_read: assert property (p_read)
    else $error("wrong comparator extension read data");
endmodule
`default_nettype wire

// ---- dbgc_pkg.sv ----
/*
 package of the comparator c extension / fifo extended info block.
 assumes a byte-wide register port with byte offsets and a 125 MHz bus clock.
*/
`default_nettype none
package dbgc_pkg;
  // ==========================================
  // register offsets
  localparam logic [3:0] DBGC_OFS_CCX = 4'ha;
  localparam logic [3:0] DBGC_OFS_FX = 4'hb;
  localparam logic [3:0] DBGC_OFS_CTL = 4'he;
  // ==========================================
  // field positions
  localparam int DBGC_CCX_DIR_EN = 7;
  localparam int DBGC_CCX_DIR_VAL = 6;
  localparam int DBGC_CCX_PAGQ = 5;
  localparam int DBGC_CCX_B16 = 0;
  localparam int DBGC_FX_PAGED = 7;
  localparam int DBGC_FX_B16 = 0;
  localparam int DBGC_CTL_EN = 7;
  localparam int DBGC_CTL_BEGIN = 6;
  localparam int DBGC_PAGE_LSB = 14;
  localparam int DBGC_A17_MSB = 16;
  // ==========================================
  // widths and reset values
  localparam int DBGC_AW = 4;
  localparam int DBGC_DW = 8;
  localparam logic [7:0] DBGC_CCX_RST = 8'h00;
  localparam logic [7:0] DBGC_FX_RST = 8'h00;
  localparam logic [7:0] DBGC_ZERO8 = 8'h00;
  localparam logic DBGC_EN_RST = 1'h0;
  localparam logic DBGC_BEGIN_RST = 1'h1;
  localparam logic DBGC_DIR_WRITE = 1'h0;
  localparam logic DBGC_DIR_READ = 1'h1;
  localparam logic [16:0] DBGC_A17_ZERO = 17'h00000;
endpackage
`default_nettype wire

// ---- test_dbgc_ext.sv ----
/*
 self-checking bench for the comparator c extension block.
 assumes the core model in dbgc_core_model.sv and the package dbgc_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module test_dbgc_ext;
  import dbgc_pkg::*;
  logic mclk, rst, por, reg_wr, reg_rd, secure, fifo_capture, fifo_event_only, en_exp;
  logic bus_valid, bus_read, page_sel, lap_sel, cmp_c_match, debug_module_enable, trigger_begin;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, ccx_val;
  logic [15:0] cmp_c_addr, cpu_addr;
  logic [2:0] prog_page;
  logic [16:0] lap_addr, fifo_word;
  int n_mismatch, n_compared;
  dbgc_ext dut_u (.mclk(mclk), .rst(rst), .por(por), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_valid(bus_valid), .bus_read(bus_read), .cpu_addr(cpu_addr),
    .prog_page(prog_page), .page_sel(page_sel), .lap_sel(lap_sel), .lap_addr(lap_addr),
    .secure(secure), .cmp_c_addr(cmp_c_addr), .fifo_capture(fifo_capture),
    .fifo_event_only(fifo_event_only), .cmp_c_match(cmp_c_match), .fifo_word(fifo_word),
    .debug_module_enable(debug_module_enable), .trigger_begin(trigger_begin));
  dbgc_core_model core_u (.mclk(mclk), .bus_valid(bus_valid), .bus_read(bus_read),
    .cpu_addr(cpu_addr), .prog_page(prog_page), .page_sel(page_sel),
    .lap_sel(lap_sel), .lap_addr(lap_addr));
  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  // ========================================
  // tasks
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    {reg_rd, reg_addr} <= {1'h1, a};
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 chk("reg_rdata", {9'h0, exp}, {9'h0, reg_rdata});
    @(posedge mclk);
    #1 chk("reg_rdata idle", 17'h0, {9'h0, reg_rdata});
  endtask
  task automatic setccx(input logic [7:0] d);
    ccx_val = d;
    wr(DBGC_OFS_CCX, d);
  endtask
  task automatic pulse(input logic p);
    @(posedge mclk);
    {rst, por} <= {1'h1, p};
    @(posedge mclk);
    {rst, por} <= 2'h0;
  endtask
  // f packs read, paged, linear pointer, capture, event-only
  task automatic bus(input logic [4:0] f, input logic [2:0] pg, input logic [15:0] ca,
      input logic [16:0] la, input logic [15:0] cmp);
    logic [16:0] a;
    logic m;
    a = f[3] ? {pg, ca[13:0]} : f[2] ? la : {1'h0, ca};
    m = en_exp & (a[15:0] == cmp) & (a[16] == ccx_val[0]) & (f[3] == ccx_val[5]);
    m = m & (!ccx_val[7] | (f[4] == ccx_val[6]));
    @(posedge mclk);
    {fifo_capture, fifo_event_only, cmp_c_addr} <= {f[1], f[0], cmp};
    core_u.cycle(f[4], f[3], f[2], pg, ca, la);
    fifo_capture <= 1'h0;
    #1 chk("cmp_c_match", {16'h0, m}, {16'h0, cmp_c_match});
    if (f[1]) begin
      chk("fifo_word", f[0] ? 17'h0 : a, fifo_word);
      rdchk(DBGC_OFS_FX, {f[3] & !f[0], 6'h0, a[16] & !f[0]});
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end
  // ========================================
  // main sequence
  initial begin
    {rst, por} = 2'h3;
    {reg_wr, reg_rd, secure, fifo_capture, fifo_event_only, en_exp} = '0;
    {reg_addr, reg_wdata, cmp_c_addr, ccx_val} = '0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (3) @(posedge mclk);
    {rst, por} <= 2'h0;
    rdchk(DBGC_OFS_CCX, 8'h00);
    rdchk(DBGC_OFS_FX, 8'h00);
    rdchk(DBGC_OFS_CTL, 8'h40);
    rdchk(4'h3, 8'h00);
    wr(DBGC_OFS_FX, 8'h81);
    rdchk(DBGC_OFS_FX, 8'h00);
    setccx(8'hff);
    rdchk(DBGC_OFS_CCX, 8'he1);
    setccx(8'h00);
    bus(5'h00, 3'h0, 16'h1234, 17'h0, 16'h1234);
    wr(DBGC_OFS_CTL, 8'h80);
    en_exp = 1'h1;
    rdchk(DBGC_OFS_CTL, 8'h80);
    bus(5'h00, 3'h0, 16'h1234, 17'h0, 16'h1234);
    bus(5'h10, 3'h0, 16'h1234, 17'h0, 16'h1234);
    setccx(8'h80);
    bus(5'h10, 3'h0, 16'h1234, 17'h0, 16'h1234);
    bus(5'h00, 3'h0, 16'h1234, 17'h0, 16'h1234);
    setccx(8'hc0);
    bus(5'h10, 3'h0, 16'h1234, 17'h0, 16'h1234);
    bus(5'h00, 3'h0, 16'h1234, 17'h0, 16'h1234);
    setccx(8'h21);
    bus(5'h0a, 3'h5, 16'hbeef, 17'h0, 16'h7eef);
    bus(5'h00, 3'h5, 16'h7eef, 17'h0, 16'h7eef);
    setccx(8'h20);
    bus(5'h08, 3'h5, 16'hbeef, 17'h0, 16'h7eef);
    setccx(8'h01);
    bus(5'h00, 3'h0, 16'ha5a5, 17'h0, 16'ha5a5);
    setccx(8'h00);
    bus(5'h02, 3'h0, 16'ha5a5, 17'h0, 16'ha5a5);
    bus(5'h03, 3'h0, 16'ha5a5, 17'h0, 16'ha5a5);
    setccx(8'h01);
    bus(5'h06, 3'h0, 16'h0, 17'h12345, 16'h2345);
    setccx(8'he1);
    pulse(1'h0);
    rdchk(DBGC_OFS_CCX, 8'he1);
    rdchk(DBGC_OFS_FX, 8'h01);
    rdchk(DBGC_OFS_CTL, 8'h80);
    wr(DBGC_OFS_CTL, 8'hc0);
    pulse(1'h0);
    rdchk(DBGC_OFS_CCX, 8'h00);
    rdchk(DBGC_OFS_FX, 8'h00);
    setccx(8'he1);
    wr(DBGC_OFS_CTL, 8'h80);
    pulse(1'h1);
    rdchk(DBGC_OFS_CCX, 8'h00);
    rdchk(DBGC_OFS_CTL, 8'h40);
    @(posedge mclk);
    secure <= 1'h1;
    wr(DBGC_OFS_CTL, 8'h80);
    rdchk(DBGC_OFS_CTL, 8'h00);
    chk("debug_module_enable", 17'h0, {16'h0, debug_module_enable});
    chk("trigger_begin", 17'h0, {16'h0, trigger_begin});
    summarize();
  end
endmodule
`default_nettype wire
